//--- hdl/fgt_pkg.sv
// constants and types for the fine-gain trim register bank
package fgt_pkg;
    localparam int FGT_ADDR_W = 12;
    localparam int FGT_DATA_W = 8;
    localparam int FGT_CODE_W = 5;
    localparam int FGT_CODE_MSB = 4;
    localparam int FGT_NREG = 6;
    localparam logic [11:0] FGT_OFS_CORE2_A = 12'h362;
    localparam logic [11:0] FGT_OFS_CORE2_B = 12'h363;
    localparam logic [11:0] FGT_OFS_CORE3_C = 12'h364;
    localparam logic [11:0] FGT_OFS_CORE3_D = 12'h365;
    localparam logic [11:0] FGT_OFS_CORE4 = 12'h366;
    localparam logic [11:0] FGT_OFS_CORE5 = 12'h367;
    localparam logic [7:0] FGT_RESET_VAL = 8'h00;
    localparam logic [2:0] FGT_RSVD_VAL = 3'h0;
    localparam logic [2:0] FGT_IDX_CORE2_A = 3'h0;
    localparam logic [2:0] FGT_IDX_CORE2_B = 3'h1;
    localparam logic [2:0] FGT_IDX_CORE3_C = 3'h2;
    localparam logic [2:0] FGT_IDX_CORE3_D = 3'h3;
    localparam logic [2:0] FGT_IDX_CORE4 = 3'h4;
    localparam logic [2:0] FGT_IDX_CORE5 = 3'h5;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fgt_bus_s;

    typedef struct packed {
        logic [4:0] core2;
        logic [4:0] core3;
        logic [4:0] core4;
        logic [4:0] core5;
    } fgt_gain_s;

    typedef enum logic [1:0] {
        FGT_LOAD_IDLE,
        FGT_LOAD_RUN,
        FGT_LOAD_DONE
    } fgt_load_e;
endpackage

//--- hdl/fgt_trim_reg.sv
// one fine-gain trim register with fuse default load and software write
`timescale 1ns/1ns
module fgt_trim_reg
    import fgt_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // load and write controls
    input wire logic fuse_load,
    input wire logic [4:0] fuse_code,
    input wire logic sw_write,
    input wire logic [7:0] sw_data,
    // stored value
    output logic [7:0] value
);
    logic [7:0] next_value;

    always_comb begin
        next_value = value;
        // software write wins over a fuse load in the same cycle
        if (sw_write) begin
            next_value = sw_data;
        end else if (fuse_load) begin
            next_value = {FGT_RSVD_VAL, fuse_code};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            value <= FGT_RESET_VAL;
        end else begin
            value <= next_value;
        end
    end
endmodule

//--- hdl/fgt_bank.sv
// fine-gain trim register bank with gain code selection on the shared cores 2 and 3
`timescale 1ns/1ns
module fgt_bank
    import fgt_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // factory trim from fuse storage, stable while fuse_valid is high
    input wire logic fuse_valid,
    input wire logic [29:0] fuse_codes,
    // input selection per shared core
    input wire logic core2_sel_b,
    input wire logic core3_sel_d,
    // gain codes to the converter cores
    output fgt_gain_s gain,
    output logic fuse_loaded
);
    fgt_bus_s bus;
    fgt_load_e load_state, next_load_state;
    logic [7:0] regs [FGT_NREG];
    logic [FGT_NREG-1:0] wr_hit;
    logic fuse_load;
    logic [7:0] next_rdata;
    fgt_gain_s next_gain;
    logic next_fuse_loaded;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    function automatic logic [2:0] fgt_index(input logic [11:0] a);
        case (a)
            FGT_OFS_CORE2_A: fgt_index = FGT_IDX_CORE2_A;
            FGT_OFS_CORE2_B: fgt_index = FGT_IDX_CORE2_B;
            FGT_OFS_CORE3_C: fgt_index = FGT_IDX_CORE3_C;
            FGT_OFS_CORE3_D: fgt_index = FGT_IDX_CORE3_D;
            FGT_OFS_CORE4: fgt_index = FGT_IDX_CORE4;
            FGT_OFS_CORE5: fgt_index = FGT_IDX_CORE5;
            default: fgt_index = 3'h7;
        endcase
    endfunction

    // fuse default load: one shot after reset once the fuse data is valid
    always_comb begin
        next_load_state = load_state;
        fuse_load = 1'b0;
        case (load_state)
            FGT_LOAD_IDLE: begin
                if (fuse_valid) begin
                    next_load_state = FGT_LOAD_RUN;
                end
            end
            FGT_LOAD_RUN: begin
                fuse_load = 1'b1;
                next_load_state = FGT_LOAD_DONE;
            end
            FGT_LOAD_DONE: begin
                next_load_state = FGT_LOAD_DONE;
            end
            default: begin
                next_load_state = FGT_LOAD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            load_state <= FGT_LOAD_IDLE;
        end else begin
            load_state <= next_load_state;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < FGT_NREG; gi++) begin : g_reg
            assign wr_hit[gi] = bus.wr && (fgt_index(bus.addr) == 3'(gi));
            fgt_trim_reg u_reg (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .fuse_load(fuse_load),
                .fuse_code(fuse_codes[gi*FGT_CODE_W +: FGT_CODE_W]),
                .sw_write(wr_hit[gi]),
                // reserved bits stored as written; software keeps them zero
                .sw_data(bus.wdata),
                .value(regs[gi])
            );
        end
    endgenerate

    // read data, gain codes and load status, all registered
    always_comb begin
        next_rdata = 8'h00;
        if (bus.rd && fgt_index(bus.addr) != 3'h7) begin
            next_rdata = regs[fgt_index(bus.addr)];
        end
        // code passed straight through, no mapping to gain steps
        next_gain.core2 = core2_sel_b ? regs[FGT_IDX_CORE2_B][FGT_CODE_MSB:0]
                                      : regs[FGT_IDX_CORE2_A][FGT_CODE_MSB:0];
        next_gain.core3 = core3_sel_d ? regs[FGT_IDX_CORE3_D][FGT_CODE_MSB:0]
                                      : regs[FGT_IDX_CORE3_C][FGT_CODE_MSB:0];
        next_gain.core4 = regs[FGT_IDX_CORE4][FGT_CODE_MSB:0];
        next_gain.core5 = regs[FGT_IDX_CORE5][FGT_CODE_MSB:0];
        next_fuse_loaded = (next_load_state == FGT_LOAD_DONE);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
            gain <= '0;
            fuse_loaded <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            gain <= next_gain;
            fuse_loaded <= next_fuse_loaded;
        end
    end

    property p_core2_b;
        @(posedge ref_clk) disable iff (!nrst)
        core2_sel_b |=> gain.core2 == $past(regs[FGT_IDX_CORE2_B][4:0]);
    endproperty
    a_core2_b: assert property (p_core2_b) else $error("core2 B code wrong");

    property p_core2_a;
        @(posedge ref_clk) disable iff (!nrst)
        !core2_sel_b |=> gain.core2 == $past(regs[FGT_IDX_CORE2_A][4:0]);
    endproperty
    a_core2_a: assert property (p_core2_a) else $error("core2 A code wrong");

    property p_core3_c;
        @(posedge ref_clk) disable iff (!nrst)
        !core3_sel_d |=> gain.core3 == $past(regs[FGT_IDX_CORE3_C][4:0]);
    endproperty
    a_core3_c: assert property (p_core3_c) else $error("core3 C code wrong");

    property p_core3_d;
        @(posedge ref_clk) disable iff (!nrst)
        core3_sel_d |=> gain.core3 == $past(regs[FGT_IDX_CORE3_D][4:0]);
    endproperty
    a_core3_d: assert property (p_core3_d) else $error("core3 D code wrong");

    property p_core4_wr;
        @(posedge ref_clk) disable iff (!nrst)
        (reg_wr && reg_addr == FGT_OFS_CORE4) ##1 !(reg_wr && reg_addr == FGT_OFS_CORE4)
        |=> gain.core4 == $past(reg_wdata[4:0], 2);
    endproperty
    a_core4_wr: assert property (p_core4_wr) else $error("core4 code not applied");

    property p_core5_rd;
        @(posedge ref_clk) disable iff (!nrst)
        (reg_rd && reg_addr == FGT_OFS_CORE5) |=> reg_rdata[4:0] == gain.core5;
    endproperty
    a_core5_rd: assert property (p_core5_rd) else $error("core5 readback mismatch");

    property p_fuse_once;
        @(posedge ref_clk) disable iff (!nrst)
        (load_state == FGT_LOAD_RUN) |=> load_state == FGT_LOAD_DONE ##1 fuse_loaded;
    endproperty
    a_fuse_once: assert property (p_fuse_once) else $error("fuse load not finished");

    property p_fuse_val;
        @(posedge ref_clk) disable iff (!nrst)
        (fuse_load && !wr_hit[FGT_IDX_CORE4])
        |=> regs[FGT_IDX_CORE4]
            == {FGT_RSVD_VAL, $past(fuse_codes[FGT_IDX_CORE4*FGT_CODE_W +: FGT_CODE_W])};
    endproperty
    a_fuse_val: assert property (p_fuse_val) else $error("fuse default not loaded");

    property p_unmapped;
        @(posedge ref_clk) disable iff (!nrst)
        (reg_rd && fgt_index(reg_addr) == 3'h7) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    c_fuse: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(fuse_loaded));
    c_sel_b: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(core2_sel_b));
    c_sel_d: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(core3_sel_d));
    c_wr_rd: cover property (@(posedge ref_clk) disable iff (!nrst) reg_wr ##1 reg_rd);
endmodule

//--- bench/testbench.sv
// self-checking bench for the fine-gain trim register bank
`timescale 1ns/1ns
module testbench;
    import fgt_pkg::*;
    localparam logic [29:0] FUSE = {5'h0A, 5'h15, 5'h07, 5'h1C, 5'h03, 5'h11};
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic fuse_valid = 1'b0;
    logic [29:0] fuse_codes = 30'h0;
    logic core2_sel_b = 1'b0;
    logic core3_sel_d = 1'b0;
    fgt_gain_s gain;
    logic fuse_loaded;
    int fails = 0;
    int n_tests = 0;
    logic [7:0] v [6];
    logic [11:0] ofs [6];

    fgt_bank uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fuse_valid(fuse_valid), .fuse_codes(fuse_codes), .core2_sel_b(core2_sel_b),
        .core3_sel_d(core3_sel_d), .gain(gain), .fuse_loaded(fuse_loaded));

    always #10 ref_clk = ~ref_clk;

    task automatic check(input logic [19:0] seen, input logic [19:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] want);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check({12'h000, reg_rdata}, {12'h000, want});
    endtask

    task automatic gain_chk(input logic b, input logic d);
        @(posedge ref_clk);
        core2_sel_b <= b;
        core3_sel_d <= d;
        repeat (3) @(posedge ref_clk);
        #1 check(gain, {(b ? v[1][4:0] : v[0][4:0]), (d ? v[3][4:0] : v[2][4:0]),
            v[4][4:0], v[5][4:0]});
    endtask

    task automatic t_reset;
        for (int i = 0; i < 6; i++) begin
            v[i] = 8'h00;
            rd_chk(ofs[i], 8'h00);
        end
        check({19'h0, fuse_loaded}, 20'h0);
        gain_chk(1'b0, 1'b0);
    endtask

    task automatic t_fuse;
        int k;
        @(posedge ref_clk);
        fuse_codes <= FUSE;
        fuse_valid <= 1'b1;
        for (k = 0; k < 20 && fuse_loaded !== 1'b1; k++) begin
            @(posedge ref_clk);
        end
        #1 check({19'h0, fuse_loaded}, 20'h1);
        for (int i = 0; i < 6; i++) begin
            v[i] = {3'h0, FUSE[5*i +: 5]};
            rd_chk(ofs[i], v[i]);
        end
        for (int i = 0; i < 4; i++) begin
            gain_chk(i[0], i[1]);
        end
        // a second fuse strobe must not reload the defaults
        @(posedge ref_clk);
        fuse_codes <= ~FUSE;
        fuse_valid <= 1'b0;
        @(posedge ref_clk);
        fuse_valid <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 6; i++) begin
            rd_chk(ofs[i], v[i]);
        end
    endtask

    task automatic t_write;
        logic [7:0] w [6];
        w = '{8'h1F, 8'h00, 8'h15, 8'h0A, 8'h01, 8'h10};
        for (int i = 0; i < 6; i++) begin
            v[i] = w[i];
            wr(ofs[i], w[i]);
        end
        for (int i = 0; i < 6; i++) begin
            rd_chk(ofs[i], v[i]);
        end
        gain_chk(1'b1, 1'b0);
        gain_chk(1'b0, 1'b1);
        // neighbours of the mapped window are not registers
        wr(12'h368, 8'h1F);
        wr(12'h361, 8'h1F);
        rd_chk(12'h368, 8'h00);
        rd_chk(12'h361, 8'h00);
        rd_chk(ofs[5], v[5]);
        rd_chk(ofs[0], v[0]);
    endtask

    // write then read with no gap; read data stand one cycle only
    task automatic t_b2b;
        @(posedge ref_clk);
        reg_addr <= FGT_OFS_CORE4;
        reg_wdata <= 8'h0B;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        v[4] = 8'h0B;
        #1 check({12'h000, reg_rdata}, {12'h000, v[4]});
        @(posedge ref_clk);
        #1 check({12'h000, reg_rdata}, 20'h0);
        check(gain, {v[0][4:0], v[3][4:0], v[4][4:0], v[5][4:0]});
    endtask

    // reset in mid-run clears the bank, then the fuse defaults load again
    task automatic t_rerst;
        @(posedge ref_clk);
        nrst <= 1'b0;
        fuse_codes <= FUSE;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        #1 check({19'h0, fuse_loaded}, 20'h0);
        check(gain, 20'h0);
        @(posedge ref_clk);
        #1 check({19'h0, fuse_loaded}, 20'h0);
        @(posedge ref_clk);
        #1 check({19'h0, fuse_loaded}, 20'h1);
        for (int i = 0; i < 6; i++) begin
            v[i] = {3'h0, FUSE[5*i +: 5]};
            rd_chk(ofs[i], v[i]);
        end
        gain_chk(1'b1, 1'b1);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ofs = '{FGT_OFS_CORE2_A, FGT_OFS_CORE2_B, FGT_OFS_CORE3_C, FGT_OFS_CORE3_D,
            FGT_OFS_CORE4, FGT_OFS_CORE5};
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_fuse();
        t_write();
        t_b2b();
        t_rerst();
        tally_and_finish();
    end

    // whole run needs well under 600 cycles
    initial begin
        repeat (2000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
endmodule
